// ### rtl/tacho_supervisor.sv
// Supervisor logic: ratio bar, hold, configuration mode, key lock and service alarm.
//
// How it works
// - Ratio mode with high/low limit or area output drives bar from measurement progress.
// - Forced dark mode blanks all bar segments.
// - Forced lit mode lights all bar segments.
// - Six segments, one per sixth of span from comparison 1 to 2.
// - Run time readable only, in tenths of a year.
// - Entering configuration mode clears present value, outputs off, measuring stops.
// - Edited configuration takes effect on return to run mode; lock level, bar mode and peak display are live in run mode.
// - Configuration change reinitialises set value and both comparison values.
// - Hold input freezes displayed measurement and outputs.
// - Reset key or reset input release clears peak and bottom when shown.
// - Lock restrictions and lock lamp follow the key-lock switch exactly.
// - Lock levels 1..7; per-level gating of display, reset, up/down keys.
// - Run-time limit 0.0..99.9 years, default 10, zero disables.
// - Run time at or above nonzero limit raises service alarm.
// - Count limit in thousands 0..9999, default 100 thousand, zero disables.
// - Switching count at or above nonzero limit raises service alarm.
// - Count monitor shows count over one thousand, read only.
// - Reset key hides alarm display; accumulators keep running.
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
module tacho_supervisor #(
  parameter int unsigned HOLD_CYCLES  = tacho_pkg::CFG_HOLD_CYCLES,
  parameter int unsigned SEC_CYCLES   = tacho_pkg::SEC_CYCLES,
  parameter int unsigned TENTH_YEAR_S = tacho_pkg::YEAR_TENTH_S
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire tacho_pkg::panel_t  panel,
  input  wire logic               meas_valid,
  input  wire logic [23:0]        meas_value,
  input  wire logic [1:0]         cmp_out_in,
  output logic      [5:0]         status_bar,
  output logic      [1:0]         cmp_out,
  output logic      [23:0]        shown_meas,
  output logic                    cfg_mode,
  output logic                    measure_en,
  output logic                    keylock_lamp,
  output logic                    service_due_alarm,
  output logic                    service_due_display
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  tacho_pkg::panel_t sync1_q, sync2_q, prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= panel;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key-lock decoding.
  function automatic logic [2:0] lock_allow(input logic on, input logic [2:0] lvl);
    // Returns {display, reset, updown}.
    logic [2:0] a;
    a = 3'h7;
    if (on) begin
      a[2] = (lvl >= 3'h1) && (lvl <= 3'h4);
      a[1] = (lvl == 3'h1) || (lvl == 3'h3) || (lvl == 3'h6);
      a[0] = (lvl == 3'h1) || (lvl == 3'h2) || (lvl == 3'h6) || (lvl == 3'h7);
    end
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file state.
  tacho_pkg::ctrl_t ctrl_q, ctrl_d, act_q, act_d;
  logic [23:0] cmp1_q, cmp1_d, cmp2_q, cmp2_d, setval_q, setval_d;
  logic [9:0]  rtlim_q, rtlim_d;
  logic [13:0] cntlim_q, cntlim_d;
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  addr_q, addr_d;

  logic [2:0]  allow;
  logic        ena_disp, ena_rst, ena_ud;
  logic        rst_press, ud_press;
  logic        cfg_q, cfg_d;
  logic [31:0] hold_cnt_q, hold_cnt_d;
  logic        combo;

  assign allow    = lock_allow(sync2_q.keylock_sw, act_q.lock_level);
  assign ena_disp = allow[2];
  assign ena_rst  = allow[1];
  assign ena_ud   = allow[0];
  assign rst_press = sync2_q.reset_key && !prev_q.reset_key && ena_rst;
  assign ud_press  = ena_ud;
  assign keylock_lamp = sync2_q.keylock_sw;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration mode entry and exit.
  // Entry to configuration mode is refused at every lock level while the switch is on.
  assign combo = !sync2_q.keylock_sw &&
                 ((sync2_q.digit1_increment_key && sync2_q.digit6_increment_key) ||
                  (sync2_q.digit1_decrement_key && sync2_q.digit6_decrement_key));

  logic bus_wr, cmd_exit;
  assign bus_wr   = wr_pend_q;
  assign cmd_exit = bus_wr && (addr_q == tacho_pkg::ADDR_CMD) && hwdata[0];

  always_comb begin
    hold_cnt_d = combo ? hold_cnt_q : 32'h0;
    cfg_d      = cfg_q;
    if (combo && !cfg_q) begin
      if (hold_cnt_q >= HOLD_CYCLES - 1) begin
        cfg_d = 1'b1;
      end else begin
        hold_cnt_d = hold_cnt_q + 32'h1;
      end
    end
    if (cfg_q && cmd_exit) begin
      cfg_d = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q      <= 1'b0;
      hold_cnt_q <= 32'h0;
    end else begin
      cfg_q      <= cfg_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  assign cfg_mode   = cfg_q;
  assign measure_en = !cfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave; zero wait states, always OKAY.
  logic bus_req;
  assign bus_req = hsel && htrans[1] && hready;

  always_comb begin
    ctrl_d    = ctrl_q;
    act_d     = act_q;
    cmp1_d    = cmp1_q;
    cmp2_d    = cmp2_q;
    setval_d  = setval_q;
    rtlim_d   = rtlim_q;
    cntlim_d  = cntlim_q;
    wr_pend_d = bus_req && hwrite;
    addr_d    = bus_req ? haddr[7:0] : addr_q;
    if (bus_wr) begin
      case (addr_q)
        tacho_pkg::ADDR_CTRL:      ctrl_d = tacho_pkg::ctrl_t'(hwdata[11:0]);
        tacho_pkg::ADDR_CMP1:      if (ud_press) cmp1_d = hwdata[23:0];
        tacho_pkg::ADDR_CMP2:      if (ud_press) cmp2_d = hwdata[23:0];
        tacho_pkg::ADDR_SETVAL:    if (ud_press) setval_d = hwdata[23:0];
        tacho_pkg::ADDR_RT_LIMIT:  rtlim_d  = (hwdata[9:0] > tacho_pkg::RT_MAX) ? tacho_pkg::RT_MAX
                                              : hwdata[9:0];
        tacho_pkg::ADDR_CNT_LIMIT: cntlim_d = (hwdata[13:0] > tacho_pkg::CNT_MAX) ? tacho_pkg::CNT_MAX
                                              : hwdata[13:0];
        default: ;
      endcase
    end
    // Edits are staged in ctrl_q and copied to the active set on exit; three fields are also copied live outside configuration mode.
    if (cfg_q && !cfg_d) begin
      act_d = ctrl_q;
      if (ctrl_q.cfg_sel != act_q.cfg_sel) begin
        cmp1_d   = tacho_pkg::CMP1_RST;
        cmp2_d   = tacho_pkg::CMP2_RST;
        setval_d = tacho_pkg::SETVAL_RST;
      end
    end
    if (!cfg_q) begin
      // Outside configuration mode lock level, bar mode and peak display (gated by the display lock) are live edits.
      act_d.lock_level         = ctrl_d.lock_level;
      act_d.indicator_bar_mode = ctrl_d.indicator_bar_mode;
      act_d.show_peak          = ctrl_d.show_peak && ena_disp;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= tacho_pkg::ctrl_t'({3'h0, tacho_pkg::LOCK_RST, 6'h00});
      act_q     <= tacho_pkg::ctrl_t'({3'h0, tacho_pkg::LOCK_RST, 6'h00});
      cmp1_q    <= tacho_pkg::CMP1_RST;
      cmp2_q    <= tacho_pkg::CMP2_RST;
      setval_q  <= tacho_pkg::SETVAL_RST;
      rtlim_q   <= tacho_pkg::RT_LIMIT_RST;
      cntlim_q  <= tacho_pkg::CNT_LIMIT_RST;
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      ctrl_q    <= ctrl_d;
      act_q     <= act_d;
      cmp1_q    <= cmp1_d;
      cmp2_q    <= cmp2_d;
      setval_q  <= setval_d;
      rtlim_q   <= rtlim_d;
      cntlim_q  <= cntlim_d;
      wr_pend_q <= wr_pend_d;
      addr_q    <= addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement, hold, outputs, extremes and bar.
  logic [23:0] meas_q, meas_d, peak_q, peak_d, bot_q, bot_d;
  logic [1:0]  out_q, out_d;
  logic [5:0]  bar_q, bar_d;
  logic [2:0]  segs;
  logic        rst_ext;
  logic [26:0] span, prog6;

  assign span  = {3'h0, cmp2_q} - {3'h0, cmp1_q};
  assign prog6 = ({3'h0, meas_value} - {3'h0, cmp1_q}) * 27'h6;
  always_comb begin
    segs = 3'h0;
    if (meas_value <= cmp1_q || cmp2_q <= cmp1_q) begin
      segs = (meas_value >= cmp2_q && cmp2_q > cmp1_q) ? 3'h6 : 3'h0;
    end else if (meas_value >= cmp2_q) begin
      segs = 3'h6;
    end else begin
      for (int k = 1; k <= 6; k++) begin
        if (prog6 >= span * 27'(k)) segs = 3'(k);
      end
    end
  end

  assign rst_ext = (!sync2_q.reset1_in && prev_q.reset1_in) ||
                   (act_q.two_input && !sync2_q.reset2_in && prev_q.reset2_in);

  always_comb begin
    meas_d = meas_q;
    out_d  = out_q;
    peak_d = peak_q;
    bot_d  = bot_q;
    bar_d  = bar_q;
    if (cfg_q) begin
      meas_d = 24'h0;
      out_d  = 2'h0;
      peak_d = 24'h0;
      bot_d  = 24'hffffff;
    end else if (!sync2_q.hold_in) begin
      out_d = cmp_out_in;
      if (meas_valid) begin
        meas_d = meas_value;
        if (meas_value > peak_q) peak_d = meas_value;
        if (meas_value < bot_q)  bot_d  = meas_value;
        if ((act_q.out_mode == tacho_pkg::OUT_HI_LO) || (act_q.out_mode == tacho_pkg::OUT_AREA)) begin
          bar_d = 6'h3f >> (3'h6 - segs);
        end else begin
          bar_d = 6'h00;
        end
      end
    end
    if (!cfg_q && act_q.show_peak && (rst_press || rst_ext)) begin
      peak_d = 24'h0;
      bot_d  = 24'hffffff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meas_q <= 24'h0;
      out_q  <= 2'h0;
      peak_q <= 24'h0;
      bot_q  <= 24'hffffff;
      bar_q  <= 6'h00;
    end else begin
      meas_q <= meas_d;
      out_q  <= out_d;
      peak_q <= peak_d;
      bot_q  <= bot_d;
      bar_q  <= bar_d;
    end
  end

  assign shown_meas = meas_q;
  assign cmp_out    = out_q;

  always_comb begin
    case (act_q.indicator_bar_mode)
      tacho_pkg::bar_forced_dark: status_bar = 6'h00;
      tacho_pkg::bar_forced_lit:  status_bar = 6'h3f;
      tacho_pkg::BAR_RATIO:       status_bar = bar_q;
      default:                    status_bar = 6'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run time and switching count accumulators, service alarm.
  logic [31:0] cyc_q, cyc_d, sec_q, sec_d;
  logic [9:0]  rt_q, rt_d, sub_q, sub_d;
  logic [13:0] cnt_q, cnt_d;
  logic        supp_q, supp_d;
  logic [1:0]  out_prev_q;

  always_comb begin
    cyc_d = cyc_q + 32'h1;
    sec_d = sec_q;
    rt_d  = rt_q;
    sub_d = sub_q;
    cnt_d = cnt_q;
    if (cyc_q >= SEC_CYCLES - 1) begin
      cyc_d = 32'h0;
      sec_d = sec_q + 32'h1;
      if (sec_q >= TENTH_YEAR_S - 1) begin
        sec_d = 32'h0;
        if (rt_q != 10'h3ff) rt_d = rt_q + 10'h1;
      end
    end
    // A cycle with a rising edge on either output is one switching; counted in thousands.
    if (|(out_q & ~out_prev_q)) begin
      if (sub_q >= tacho_pkg::CNT_PER_UNIT - 10'h1) begin
        sub_d = 10'h0;
        if (cnt_q != 14'h3fff) cnt_d = cnt_q + 14'h1;
      end else begin
        sub_d = sub_q + 10'h1;
      end
    end
    supp_d = supp_q || rst_press;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_q <= 32'h0;
      sec_q <= 32'h0;
      rt_q  <= 10'h0;
      sub_q <= 10'h0;
      cnt_q <= 14'h0;
      supp_q <= 1'b0;
      out_prev_q <= 2'h0;
    end else begin
      cyc_q <= cyc_d;
      sec_q <= sec_d;
      rt_q  <= rt_d;
      sub_q <= sub_d;
      cnt_q <= cnt_d;
      supp_q <= supp_d;
      out_prev_q <= out_q;
    end
  end

  assign service_due_alarm = ((rtlim_q != 10'h0) && (rt_q >= rtlim_q)) ||
                             ((cntlim_q != 14'h0) && (cnt_q >= cntlim_q));
  assign service_due_display = service_due_alarm && !supp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered so that hrdata comes from flip-flops.
  logic [31:0] rdata_q, rdata_d;
  always_comb begin
    rdata_d = rdata_q;
    if (bus_req && !hwrite) begin
      case (haddr[7:0])
        tacho_pkg::ADDR_CTRL:      rdata_d = {20'h0, ctrl_q};
        tacho_pkg::ADDR_CMP1:      rdata_d = {8'h0, cmp1_q};
        tacho_pkg::ADDR_CMP2:      rdata_d = {8'h0, cmp2_q};
        tacho_pkg::ADDR_SETVAL:    rdata_d = {8'h0, setval_q};
        tacho_pkg::ADDR_MEAS:      rdata_d = {8'h0, meas_q};
        tacho_pkg::ADDR_RT_LIMIT:  rdata_d = {22'h0, rtlim_q};
        tacho_pkg::ADDR_CNT_LIMIT: rdata_d = {18'h0, cntlim_q};
        tacho_pkg::ADDR_RT_MON:    rdata_d = {22'h0, rt_q};
        tacho_pkg::ADDR_CNT_MON:   rdata_d = {18'h0, cnt_q};
        tacho_pkg::ADDR_STATUS:    rdata_d = {19'h0, keylock_lamp, service_due_display, service_due_alarm,
                                              cfg_q, status_bar, 1'b0, out_q};
        default:                   rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

// ### rtl/tacho_pkg.sv
// Package of constants, register map and carrier types for the tachometer supervisor.
package tacho_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CFG_HOLD_MS     = 2000;
  localparam int unsigned CFG_HOLD_CYCLES = CFG_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned YEAR_TENTH_S    = 3_155_760;
  localparam int unsigned SEC_CYCLES      = CLK_HZ;

  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_CMP1      = 8'h04;
  localparam logic [7:0] ADDR_CMP2      = 8'h08;
  localparam logic [7:0] ADDR_MEAS      = 8'h0c;
  localparam logic [7:0] ADDR_RT_LIMIT  = 8'h10;
  localparam logic [7:0] ADDR_CNT_LIMIT = 8'h14;
  localparam logic [7:0] ADDR_RT_MON    = 8'h18;
  localparam logic [7:0] ADDR_CNT_MON   = 8'h1c;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;
  localparam logic [7:0] ADDR_CMD       = 8'h24;
  localparam logic [7:0] ADDR_SETVAL    = 8'h28;

  localparam logic [9:0]  RT_LIMIT_RST  = 10'h064;
  localparam logic [13:0] CNT_LIMIT_RST = 14'h0064;
  localparam logic [2:0]  LOCK_RST      = 3'h1;
  localparam logic [23:0] CMP1_RST      = 24'h000000;
  localparam logic [23:0] CMP2_RST      = 24'h000000;
  localparam logic [23:0] SETVAL_RST    = 24'h000000;
  localparam logic [9:0]  RT_MAX        = 10'h3e7;
  localparam logic [13:0] CNT_MAX       = 14'h270f;
  localparam logic [9:0]  CNT_PER_UNIT  = 10'h3e8;

  typedef enum logic [1:0] {
    BAR_OFF         = 2'h0,
    BAR_RATIO       = 2'h1,
    bar_forced_dark = 2'h2,
    bar_forced_lit  = 2'h3
  } bar_mode_t;

  typedef enum logic [1:0] {
    OUT_HI_LO = 2'h0,
    OUT_AREA  = 2'h1,
    OUT_HI_HI = 2'h2,
    OUT_LO_LO = 2'h3
  } out_mode_t;

  // Control word as software writes it.
  typedef struct packed {
    logic [2:0] cfg_sel;
    logic [2:0] lock_level;
    logic       two_input;
    logic       show_peak;
    out_mode_t  out_mode;
    bar_mode_t  indicator_bar_mode;
  } ctrl_t;

  // Front-panel keys and external inputs.
  typedef struct packed {
    logic digit1_increment_key;
    logic digit1_decrement_key;
    logic digit6_increment_key;
    logic digit6_decrement_key;
    logic reset_key;
    logic mode_key;
    logic display_key;
    logic hold_in;
    logic reset1_in;
    logic reset2_in;
    logic keylock_sw;
  } panel_t;

endpackage

// ### verif/tacho_supervisor_props.sv
// Port-level checker for the tachometer supervisor, bound to its top module.
module tacho_supervisor_props #(
  parameter int unsigned HOLD_CYCLES = 20
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire tacho_pkg::panel_t panel,
  input wire logic [5:0]        status_bar,
  input wire logic [1:0]        cmp_out,
  input wire logic [23:0]       shown_meas,
  input wire logic              cfg_mode,
  input wire logic              measure_en,
  input wire logic              keylock_lamp,
  input wire logic              service_due_alarm,
  input wire logic              service_due_display
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////
  // The pin-side press count runs ahead of the synchroniser, hence the slack below.
  logic [31:0] pair_q;
  logic [31:0] pair_d;
  always_comb begin
    pair_d = 32'h0;
    if ((panel.digit1_increment_key && panel.digit6_increment_key) ||
        (panel.digit1_decrement_key && panel.digit6_decrement_key)) begin
      pair_d = pair_q + 32'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pair_q <= 32'h0;
    end else begin
      pair_q <= pair_d;
    end
  end
  ////////////////////////////////////////
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  bar_from_left_a: assert property (status_bar inside {6'h00, 6'h01, 6'h03, 6'h07, 6'h0f, 6'h1f, 6'h3f})
    else $error("bar segments not lit from the left");
  measure_stop_a: assert property (measure_en == !cfg_mode)
    else $error("measuring runs in configuration mode");
  cfg_outputs_off_a: assert property (cfg_mode && $past(cfg_mode) |-> cmp_out == 2'h0 && shown_meas == 24'h0)
    else $error("outputs or value not cleared in configuration mode");
  hold_freeze_a: assert property (panel.hold_in [*4] |=> $stable(shown_meas) && $stable(cmp_out))
    else $error("value or outputs moved while held");
  lamp_follow_a: assert property (keylock_lamp == $past(panel.keylock_sw, 2))
    else $error("lock lamp does not follow the switch");
  cfg_entry_hold_a: assert property ($rose(cfg_mode) |-> $past(pair_q, 3) >= HOLD_CYCLES - 2)
    else $error("configuration entered without a long press");
  display_alarm_a: assert property (service_due_display |-> service_due_alarm)
    else $error("service display without alarm");
endmodule

bind tacho_supervisor tacho_supervisor_props #(.HOLD_CYCLES(HOLD_CYCLES)) tacho_supervisor_props_inst (
  .hclk, .hresetn, .hreadyout, .hresp, .panel, .status_bar, .cmp_out, .shown_meas, .cfg_mode,
  .measure_en, .keylock_lamp, .service_due_alarm, .service_due_display
);

// ### verif/panel_model.sv
// Front-panel model: operator keys, hold and reset inputs, key-lock switch.
module panel_model (
  input  wire logic              hclk,
  input  wire tacho_pkg::panel_t req,
  input  wire logic              cfg_go,
  input  wire logic              cfg_dec,
  input  wire logic [7:0]        cfg_len,
  output tacho_pkg::panel_t      panel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q = 8'h00;
  logic       dec_q  = 1'b0;
  always_ff @(posedge hclk) begin
    if (cfg_go) begin
      left_q <= cfg_len;
      dec_q  <= cfg_dec;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  // Both keys of a pair go down and up together, so a short press stays short at the pins.
  always_comb begin
    panel = req;
    if (left_q != 8'h00) begin
      panel.digit1_increment_key = !dec_q;
      panel.digit6_increment_key = !dec_q;
      panel.digit1_decrement_key = dec_q;
      panel.digit6_decrement_key = dec_q;
    end
  end
endmodule

// ### verif/tb_tacho_supervisor.sv
// Self-checking bench for the tachometer supervisor.
module tb_tacho_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] v;
    logic [31:0] m;
  } note_t;
  localparam int C1 = 32'h7d0;
  localparam int C2 = 32'h8fc;
  localparam int LIMIT = 32'h7530;
  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel = 1'b0;
  logic [31:0]       haddr = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [31:0]       hwdata = 32'h0;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  tacho_pkg::panel_t panel_req = '0;
  tacho_pkg::panel_t panel;
  logic              cfg_go = 1'b0;
  logic              cfg_dec = 1'b0;
  logic [7:0]        cfg_len = 8'h00;
  logic              meas_valid = 1'b0;
  logic [23:0]       meas_value = 24'h0;
  logic [1:0]        cmp_in = 2'h0;
  logic [5:0]        status_bar;
  logic [1:0]        cmp_out;
  logic [23:0]       shown_meas;
  logic              cfg_mode, measure_en, keylock_lamp, alarm, display;
  logic              rd_take = 1'b0;
  logic [31:0]       rnd = 32'h0000893b;
  note_t             exp_q[$];
  note_t             nt;
  int                miscompares = 0;
  int                num_checks = 0;
  int                cycles = 0;
  int                prev;
  int                v;
  int                bar_tab[7] = '{32'h801, 32'h802, 32'h866, 32'h8fb, 32'h8fc, 32'h1388, 32'h64};

  tacho_supervisor #(.HOLD_CYCLES(20), .SEC_CYCLES(4), .TENTH_YEAR_S(2)) tacho_supervisor_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .panel, .meas_valid, .meas_value, .cmp_out_in(cmp_in), .status_bar, .cmp_out,
    .shown_meas, .cfg_mode, .measure_en, .keylock_lamp, .service_due_alarm(alarm), .service_due_display(display)
  );
  panel_model panel_model_inst (.hclk, .req(panel_req), .cfg_go, .cfg_dec, .cfg_len, .panel);

  initial begin
    forever #5 hclk = ~hclk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [31:0] bar_of(input int m);
    int n;
    n = (m < C1) ? 0 : 6 * (m - C1) / (C2 - C1);
    if (n > 6) n = 6;
    return 32'((1 << n) - 1) << 3;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t read %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Reads leave a note; the watcher below compares it at the data-phase edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (wr) hwdata <= d;
    rd_take <= !wr;
    if (!wr) exp_q.push_back('{v: d & m, m: m});
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_take <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, e, m);
  endtask
  task automatic meas(input logic [23:0] mv, input logic [1:0] c);
    @(posedge hclk);
    meas_valid <= 1'b1;
    meas_value <= mv;
    cmp_in <= c;
    @(posedge hclk);
    meas_valid <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  task automatic cfg_press(input logic dec, input logic [7:0] n);
    @(posedge hclk);
    cfg_go <= 1'b1;
    cfg_dec <= dec;
    cfg_len <= n;
    @(posedge hclk);
    cfg_go <= 1'b0;
    repeat (int'(n) + 6) @(posedge hclk);
  endtask
  task automatic set_pin(input int k, input logic on);
    @(posedge hclk);
    if (k == 0) panel_req.keylock_sw <= on;
    if (k == 1) panel_req.hold_in <= on;
    if (k == 2) panel_req.reset_key <= on;
    repeat (6) @(posedge hclk);
  endtask
  ////////////////////////////////////////
  always @(posedge hclk) begin
    if (rd_take && hreadyout) begin
      nt = exp_q.pop_front();
      check(hrdata & nt.m, nt.v);
    end
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(tacho_pkg::ADDR_RT_LIMIT, 32'hffffffff, 32'h64);
    rd(tacho_pkg::ADDR_CNT_LIMIT, 32'hffffffff, 32'h64);
    wr(tacho_pkg::ADDR_CMP1, C1);
    wr(tacho_pkg::ADDR_CMP2, C2);
    wr(tacho_pkg::ADDR_CTRL, 32'h41);
    for (int i = 0; i < 15; i++) begin
      rnd = xs(rnd);
      v = (i < 7) ? bar_tab[i] : 32'h76c + int'(rnd % 32'h1f4);
      meas(24'(v), 2'h0);
      rd(tacho_pkg::ADDR_STATUS, 32'h1f8, bar_of(v));
    end
    wr(tacho_pkg::ADDR_CTRL, 32'h42);
    meas(24'(C2), 2'h0);
    rd(tacho_pkg::ADDR_STATUS, 32'h1f8, 32'h0);
    wr(tacho_pkg::ADDR_CTRL, 32'h43);
    meas(24'(C1), 2'h0);
    rd(tacho_pkg::ADDR_STATUS, 32'h1f8, 32'h1f8);
    wr(tacho_pkg::ADDR_CTRL, 32'h41);
    meas(24'(C2), 2'h1);
    set_pin(1, 1'b1);
    meas(24'(C1), 2'h2);
    rd(tacho_pkg::ADDR_MEAS, 32'hffffff, C2);
    rd(tacho_pkg::ADDR_STATUS, 32'h3, 32'h1);
    set_pin(1, 1'b0);
    meas(24'(C1), 2'h2);
    rd(tacho_pkg::ADDR_STATUS, 32'h3, 32'h2);
    set_pin(0, 1'b1);
    rd(tacho_pkg::ADDR_STATUS, 32'h1000, 32'h1000);
    cfg_press(1'b0, 8'h1e);
    rd(tacho_pkg::ADDR_STATUS, 32'h200, 32'h0);
    prev = C1;
    for (int l = 1; l < 8; l++) begin
      wr(tacho_pkg::ADDR_CTRL, 32'h01 | (32'(l) << 6));
      wr(tacho_pkg::ADDR_CMP1, 32'(l));
      if (l inside {1, 2, 6, 7}) prev = l;
      rd(tacho_pkg::ADDR_CMP1, 32'hffffff, 32'(prev));
    end
    set_pin(0, 1'b0);
    wr(tacho_pkg::ADDR_CTRL, 32'hc1);
    wr(tacho_pkg::ADDR_CMP1, C1);
    rd(tacho_pkg::ADDR_CMP1, 32'hffffff, C1);
    rd(tacho_pkg::ADDR_STATUS, 32'h1000, 32'h0);
    wr(tacho_pkg::ADDR_CTRL, 32'h41);
    meas(24'(C2), 2'h1);
    for (int p = 0; p < 2; p++) begin
      cfg_press(p[0], 8'h0a);
      rd(tacho_pkg::ADDR_STATUS, 32'h200, 32'h0);
      cfg_press(p[0], 8'h1e);
      rd(tacho_pkg::ADDR_STATUS, 32'h203, 32'h200);
      meas(24'(C1), 2'h1);
      rd(tacho_pkg::ADDR_MEAS, 32'hffffff, 32'h0);
      wr(tacho_pkg::ADDR_CTRL, 32'h41 | (32'(p + 1) << 9) | (32'(p) << 3));
      rd(tacho_pkg::ADDR_CMP1, 32'hffffff, C1);
      wr(tacho_pkg::ADDR_CMD, 32'h1);
      rd(tacho_pkg::ADDR_CMP1, 32'hffffff, 32'(tacho_pkg::CMP1_RST));
      rd(tacho_pkg::ADDR_CMP2, 32'hffffff, 32'(tacho_pkg::CMP2_RST));
      rd(tacho_pkg::ADDR_SETVAL, 32'hffffff, 32'(tacho_pkg::SETVAL_RST));
      wr(tacho_pkg::ADDR_CMP1, C1);
      wr(tacho_pkg::ADDR_CMP2, C2);
    end
    // The second pass left an upper-limit output mode active, so the ratio bar stays dark.
    meas(24'(C2), 2'h0);
    rd(tacho_pkg::ADDR_STATUS, 32'h1f8, 32'h0);
    wr(tacho_pkg::ADDR_RT_LIMIT, 32'h0);
    wr(tacho_pkg::ADDR_CNT_LIMIT, 32'h0);
    rd(tacho_pkg::ADDR_STATUS, 32'hc00, 32'h0);
    wr(tacho_pkg::ADDR_RT_MON, 32'h3e7);
    wr(tacho_pkg::ADDR_RT_LIMIT, 32'h3e8);
    rd(tacho_pkg::ADDR_RT_LIMIT, 32'hffffffff, 32'h3e7);
    rd(tacho_pkg::ADDR_STATUS, 32'h400, 32'h0);
    wr(tacho_pkg::ADDR_RT_LIMIT, 32'h1);
    rd(tacho_pkg::ADDR_STATUS, 32'h400, 32'h400);
    wr(tacho_pkg::ADDR_RT_LIMIT, 32'h0);
    wr(tacho_pkg::ADDR_CNT_LIMIT, 32'h1);
    rd(tacho_pkg::ADDR_STATUS, 32'h400, 32'h0);
    repeat (1000) begin
      meas(24'(C1), 2'h1);
      meas(24'(C1), 2'h0);
    end
    wr(tacho_pkg::ADDR_CNT_MON, 32'h5);
    rd(tacho_pkg::ADDR_CNT_MON, 32'hffffffff, 32'h1);
    rd(tacho_pkg::ADDR_STATUS, 32'hc00, 32'hc00);
    wr(tacho_pkg::ADDR_CTRL, 32'h81);
    set_pin(0, 1'b1);
    set_pin(2, 1'b1);
    set_pin(2, 1'b0);
    rd(tacho_pkg::ADDR_STATUS, 32'hc00, 32'hc00);
    set_pin(0, 1'b0);
    set_pin(2, 1'b1);
    set_pin(2, 1'b0);
    rd(tacho_pkg::ADDR_STATUS, 32'hc00, 32'h400);
    rd(tacho_pkg::ADDR_CNT_MON, 32'hffffffff, 32'h1);
    final_report();
  end
endmodule
